// ==== src/adc_fmt_cfg.svh ====
// Purpose: constants for the sample word formatter
// Assumes: single core_clk domain at 50 MHz
// Notes: codes are offset binary before format conversion
`ifndef ADC_FMT_CFG_SVH
`define ADC_FMT_CFG_SVH
`define WORD_BITS 12
`define PIPE_LATENCY 11
`define FIFO_DEPTH 8
`define CODE_POS_FS 12'hfff
`define CODE_NEG_FS 12'h000
`define MSB_FLIP 12'h800
`endif

// ==== src/adc_fmt_pkg.sv ====
// Purpose: types for the sample word formatter
// Assumes: nothing beyond the cfg header
// Notes: one-hot state codes written out
package adc_fmt_pkg;
	typedef enum logic [1:0] {
		phase_first_type_val = 2'b01,
		phase_second_type_val = 2'b10
	} phase_type;
	typedef logic [11:0] word_type;
endpackage

// ==== src/sample_fifo.sv ====
// Purpose: small synchronous fifo carrying word plus range flag
// Assumes: one clock, synchronous active-high reset
// Notes: depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;
	wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];
	always_ff @(posedge core_clk) begin
		if (do_wr)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_wr)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== src/latency_pipe.sv ====
// Purpose: fixed-length delay line for word plus flag
// Assumes: advances on every core_clk edge
// Notes: length set by caller
`timescale 1ns/1ps
`default_nettype none
module latency_pipe #(
	parameter int WIDTH = 14,
	parameter int STAGES = 11
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// stream
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage [STAGES];
	always_ff @(posedge core_clk) begin
		if (rst)
			stage[0] <= '0;
		else
			stage[0] <= din;
	end
	genvar g;
	generate
		for (g = 1; g < STAGES; g++) begin : g_stage
			always_ff @(posedge core_clk) begin
				if (rst)
					stage[g] <= '0;
				else
					stage[g] <= stage[g-1];
			end
		end
	endgenerate
	assign dout = stage[STAGES-1];
endmodule
`default_nettype wire

// ==== src/adc_output_word_formatter.sv ====
// Purpose: digital output side of a 12-bit pipelined converter
// Assumes: core_clk is the sample clock; sample_valid marks its sampling edge
// Notes: raw samples arrive as offset binary with over/under flags
// Behaviour
// - sample taken on rising true clock edge
// - word valid at next data clock rise; at full rate back-to-back words get no rise between them
// - result appears eleven cycles after sampling; half rate gives twelve when the word waits a cycle for its slot
// - select low divides clock by two
// - pulldown default selects divide by two
// - format low two's complement, high offset
// - format pulldown default gives two's complement
// - one 12-bit word, bit 11 msb
// - range flag true high, comp low
// - exact positive full scale, flag clear
// - exact negative full scale, flag clear
// - above full scale saturates positive, flagged
// - below full scale saturates negative, flagged
`timescale 1ns/1ps
`include "adc_fmt_cfg.svh"
`default_nettype none
module adc_output_word_formatter (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// straps, already resolved to their pulled-down level when open
	input wire logic half_rate_select,
	input wire logic format_select,
	// raw conversion result from the analog pipeline
	input wire logic sample_valid,
	input wire logic [11:0] raw_code,
	input wire logic above_full_scale,
	input wire logic below_full_scale,
	// parallel output
	output logic [11:0] sample_word_pairs,
	output logic over_range_true,
	output logic over_range_comp,
	output logic data_clock_out_true,
	output logic data_clock_out_comp,
	// back-pressure seen by the sampler
	output logic sample_ready
);
	localparam int PW = `WORD_BITS + 1;

	adc_fmt_pkg::phase_type phase;
	adc_fmt_pkg::phase_type next_phase;
	logic [PW:0] pipe_in;
	logic [PW:0] pipe_out;
	logic fifo_valid;
	logic fifo_ready;
	logic [PW-1:0] fifo_data;

	// saturation on range flags; offset binary is the internal form
	function automatic logic [11:0] saturate(input logic [11:0] code, input logic hi,
			input logic lo);
		if (hi)
			saturate = `CODE_POS_FS;
		else if (lo)
			saturate = `CODE_NEG_FS;
		else
			saturate = code;
	endfunction

	// offset binary to two's complement is an msb flip
	function automatic logic [11:0] to_format(input logic [11:0] code, input logic ob);
		to_format = ob ? code : (code ^ `MSB_FLIP);
	endfunction

	wire [11:0] sat_code = saturate(raw_code, above_full_scale, below_full_scale);
	wire out_of_range = above_full_scale || below_full_scale;
	// sampling happens on this rising edge, marked by sample_valid
	wire take = sample_valid && sample_ready;

	// word and flag share one delay line
	assign pipe_in = {take, out_of_range, sat_code};

	// select low: update every other cycle; high: every cycle
	wire half_rate = !half_rate_select;
	wire slot = !half_rate || (phase == adc_fmt_pkg::phase_first_type_val);
	wire drain = slot && fifo_valid;
	// half rate refuses the cycle after a take, so input never outruns the word slots
	wire next_ready = fifo_ready && !(half_rate && take);
	latency_pipe #(
		.WIDTH(PW + 1),
		.STAGES(`PIPE_LATENCY - 1)
	) u_pipe (
		.core_clk(core_clk),
		.rst(rst),
		.din(pipe_in),
		.dout(pipe_out)
	);

	// fifo absorbs words while the half-rate output waits for its slot
	sample_fifo #(
		.WIDTH(PW),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(pipe_out[PW]),
		.in_ready(fifo_ready),
		.in_data(pipe_out[PW-1:0]),
		.out_valid(fifo_valid),
		.out_ready(drain),
		.out_data(fifo_data)
	);

	always_comb begin
		case (phase)
			adc_fmt_pkg::phase_first_type_val: next_phase = half_rate ?
				adc_fmt_pkg::phase_second_type_val : adc_fmt_pkg::phase_first_type_val;
			adc_fmt_pkg::phase_second_type_val: next_phase = adc_fmt_pkg::phase_first_type_val;
			default: next_phase = adc_fmt_pkg::phase_first_type_val;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			phase <= adc_fmt_pkg::phase_first_type_val;
			sample_ready <= 1'b0;
		end else begin
			phase <= next_phase;
			sample_ready <= next_ready;
		end
	end

	// word launched with data clock low, clock rises a cycle later unless the next cycle drains another word
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sample_word_pairs <= '0;
			over_range_true <= 1'b0;
			over_range_comp <= 1'b1;
			data_clock_out_true <= 1'b0;
			data_clock_out_comp <= 1'b1;
		end else begin
			if (drain) begin
				sample_word_pairs <= to_format(fifo_data[11:0], format_select);
				over_range_true <= fifo_data[12];
				over_range_comp <= !fifo_data[12];
			end
			// data clock low in each cycle that drains a word, high otherwise
			data_clock_out_true <= drain ? 1'b0 : 1'b1;
			data_clock_out_comp <= drain ? 1'b1 : 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== test/fmt_chk.sv ====
// Purpose: port checks of the formatter
// Assumes: latency figures need an idle fifo
// Notes: bound at file foot
`timescale 1ns/1ps
`default_nettype none
module fmt_chk (
	// watched ports
	input wire logic core_clk,
	input wire logic rst,
	input wire logic half_rate_select,
	input wire logic format_select,
	input wire logic sample_valid,
	input wire logic [11:0] raw_code,
	input wire logic above_full_scale,
	input wire logic below_full_scale,
	input wire logic [11:0] sample_word_pairs,
	input wire logic over_range_true,
	input wire logic over_range_comp,
	input wire logic data_clock_out_true,
	input wire logic data_clock_out_comp,
	input wire logic sample_ready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire go = sample_valid && sample_ready;
	wire full = go && half_rate_select;
	wire oor = above_full_scale || below_full_scale;
	// msb flip turns offset binary into two's complement
	wire [11:0] flip = {~format_select, 11'h000};
	chk_or_pair: assert property (over_range_comp != over_range_true)
		else $error("range pair split");
	chk_clk_pair: assert property (data_clock_out_comp != data_clock_out_true)
		else $error("clock pair split");
	chk_word_lat: assert property (full && !oor |-> ##12 !over_range_true &&
		sample_word_pairs == ($past(raw_code, 12) ^ flip)) else $error("word wrong");
	chk_sat_high: assert property (full && above_full_scale |-> ##12 over_range_true &&
		sample_word_pairs == ~flip) else $error("high saturation wrong");
	chk_sat_low: assert property (full && below_full_scale && !above_full_scale |-> ##12
		over_range_true && sample_word_pairs == flip) else $error("low saturation wrong");
	chk_half_gap: assert property (go && !half_rate_select |=> !sample_ready)
		else $error("takes too close");
	chk_upd_low: assert property ($changed(sample_word_pairs) |-> !data_clock_out_true)
		else $error("clock high on update");
	chk_rst_out: assert property ($fell(rst) |-> sample_word_pairs == 12'h000 &&
		!over_range_true && !sample_ready) else $error("reset values wrong");
endmodule
bind adc_output_word_formatter fmt_chk chk_i (.*);
`default_nettype wire

// ==== test/word_latch.sv ====
// Purpose: receiving latch on the far side
// Assumes: a data clock rise marks a valid word
// Notes: count lets the bench see each capture
`timescale 1ns/1ps
`default_nettype none
module word_latch (
	// converter side
	input wire logic core_clk,
	input wire logic [11:0] word,
	input wire logic flag,
	input wire logic dclk,
	// captured
	output logic [11:0] cap_word,
	output logic cap_flag,
	output logic [7:0] cap_cnt = 8'h00
);
	logic prev = 1'b0;
	// rise found on core_clk, clear of the race with the word update
	always @(posedge core_clk) begin
		prev <= dclk;
		if (!prev && dclk) {cap_word, cap_flag, cap_cnt} <= {word, flag, cap_cnt + 8'h01};
	end
endmodule
`default_nettype wire

// ==== test/adc_output_word_formatter_tb.sv ====
// Purpose: formatter bench
// Assumes: 50 MHz core clock
// Notes: one word in flight at a time
`timescale 1ns/1ps
`default_nettype none
module adc_output_word_formatter_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic half_rate_select = 1'b1;
	logic format_select = 1'b0;
	logic sample_valid = 1'b0;
	logic above_full_scale = 1'b0;
	logic below_full_scale = 1'b0;
	logic [11:0] raw_code = 12'h000;
	logic [11:0] sample_word_pairs, cap_word;
	logic over_range_true, over_range_comp, data_clock_out_true, data_clock_out_comp;
	logic sample_ready, cap_flag;
	logic [7:0] cap_cnt;
	int error_cnt = 0;
	int total_checks = 0;
	always #10 core_clk = ~core_clk;
	adc_output_word_formatter DUT (.*);
	word_latch rx (.core_clk, .word(sample_word_pairs), .flag(over_range_true),
		.dclk(data_clock_out_true), .cap_word, .cap_flag, .cap_cnt);
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic tick(inout int i);
		i++;
		if (i > 60) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: timeout", $time);
			complete_run();
		end
		@(posedge core_clk) #1;
	endtask
	task automatic send(input logic [11:0] raw, input logic [1:0] r);
		logic [7:0] n;
		int i = 0;
		{raw_code, above_full_scale, below_full_scale, sample_valid} = {raw, r, 1'b1};
		while (sample_ready !== 1'b1) tick(i);
		tick(i);
		sample_valid = 1'b0;
		// count read after the take so a reset-time clock rise is not mistaken for a word
		n = cap_cnt;
		while (cap_cnt == n) tick(i);
		cmp({11'h000, cap_flag}, {11'h000, |r});
		cmp(cap_word, (r[1] ? 12'hfff : r[0] ? 12'h000 : raw) ^ {~format_select, 11'h000});
	endtask
	task automatic t_codes();
		for (int f = 0; f < 2; f++) begin
			format_select = f[0];
			send(12'hfff, 2'b00);
			send(12'h000, 2'b00);
			send(12'h5a3, 2'b10);
			send(12'h801, 2'b01);
		end
	endtask
	task automatic t_half();
		half_rate_select = 1'b0;
		send(12'h3c6, 2'b00);
		send(12'hc39, 2'b00);
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		#1 rst = 1'b0;
		t_codes();
		t_half();
		complete_run();
	end
endmodule
`default_nettype wire
